// ===== verilog/ces_top.sv
// module: exception sequencer with avalon-mm register slave
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ces_top (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  input  wire logic                 i_power_on_reset_n,
  input  wire logic                 i_manual_reset_n,
  input  wire logic                 i_debug_port_reset,
  input  ces_pkg::ces_bound_t       i_bound,
  input  ces_pkg::ces_int_t         i_int,
  input  wire logic                 i_rte,
  input  ces_pkg::ces_sw_load_t     i_sw_load,
  input  ces_pkg::ces_avs_req_t     i_avs,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  output logic [31:0]               o_status_word,
  output logic [31:0]               o_saved_pc,
  output logic [31:0]               o_saved_status_word,
  output ces_pkg::ces_redir_t       o_redirect
);
  import ces_pkg::*;

  ces_state_t             state_r;
  logic [1:0]             por_sync_r;
  logic [1:0]             man_sync_r;
  logic                   por_pend_r;
  logic [31:0]            sw_r;
  logic [31:0]            spc_r;
  logic [31:0]            ssr_r;
  logic [31:0]            vbr_r;
  logic [11:0]            exc_code_r;
  logic [11:0]            int_code_r;
  logic [11:0]            int_alt_r;
  logic [7:0]             tra_r;
  logic                   nmi_pend_r;
  logic                   nmi_prev_r;
  logic                   defer_r;
  logic [CES_GEX_W-1:0]   defer_idx_r;
  logic [7:0]             defer_imm_r;
  logic                   wait_r;
  logic [31:0]            rdata_r;
  ces_redir_t             redir_r;

  logic                   por_now;
  logic                   man_now;
  logic                   blocked;
  logic                   bnd_ok;
  logic [CES_NUM_GEX-1:0] now_cause;
  logic                   gex_take;
  logic [CES_GEX_W-1:0]   gex_idx;
  logic [7:0]             gex_imm;
  logic                   gex_found;
  logic [CES_GEX_W-1:0]   now_idx;
  logic                   nmi_take;
  logic                   irq_take;
  logic                   rst_take;
  logic                   entry;
  logic [31:0]            entry_pc;
  logic                   bus_acc;
  logic                   bus_wr;

  // lowest set index = earliest in the instruction's execution order
  function automatic logic [CES_GEX_W:0] first_cause(
    input logic [CES_NUM_GEX-1:0] c
  );
    logic [CES_GEX_W:0] res;
    res = '0;
    for (int k = CES_NUM_GEX - 1; k >= 0; k--)
    begin
      if (c[k])
      begin
        res = {1'b1, k[CES_GEX_W-1:0]};
      end
    end
    return res;
  endfunction : first_cause

  function automatic logic [31:0] merge_be(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // reset pins come from outside the clock domain
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      por_sync_r <= 2'h3;
      man_sync_r <= 2'h3;
    end
    else
    begin
      por_sync_r <= {por_sync_r[0], i_power_on_reset_n};
      man_sync_r <= {man_sync_r[0], i_manual_reset_n};
    end
  end

  assign por_now = ~por_sync_r[1] | por_pend_r;
  assign man_now = ~man_sync_r[1];
  assign blocked = sw_r[CES_SW_BLOCK];
  // boundary inside a branch/slot pair is never usable for interrupts or deferred causes
  assign bnd_ok  = i_bound.valid & ~i_bound.gap
                   & (state_r == CES_RUN);

  always_comb
  begin
    logic [CES_GEX_W:0] f;
    f         = '0;
    now_cause = i_bound.cause;
    if (i_bound.gap)
    begin
      now_cause = i_bound.cause & ~CES_GEX_DONE;
    end
    f         = first_cause(now_cause);
    gex_found = f[CES_GEX_W];
    now_idx   = f[CES_GEX_W-1:0];
  end

  // a deferred cause belongs to an earlier instruction and goes first
  always_comb
  begin
    gex_take = 1'b0;
    gex_idx  = now_idx;
    gex_imm  = i_bound.trap_imm;
    entry_pc = i_bound.pc;
    if (bnd_ok && defer_r)
    begin
      gex_take = 1'b1;
      gex_idx  = defer_idx_r;
      gex_imm  = defer_imm_r;
    end
    else if (i_bound.valid && (state_r == CES_RUN) && gex_found)
    begin
      if (i_bound.gap)
      begin
        gex_take = 1'b1;
        entry_pc = i_bound.branch_pc;
      end
      else
      begin
        gex_take = 1'b1;
      end
    end
  end

  assign rst_take = por_now | man_now | i_debug_port_reset;
  assign nmi_take = bnd_ok & ~blocked & nmi_pend_r;
  assign irq_take = bnd_ok & ~blocked & (i_int.irq | i_int.dbg_irq);
  assign entry    = ~rst_take & (gex_take | nmi_take | irq_take | i_rte);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      por_pend_r <= 1'b1;
    end
    else
    begin
      por_pend_r <= 1'b0;
    end
  end

  // nmi is sticky and armed by its rising edge, so a request level still
  // high after acceptance does not re-arm it; a new edge beats the clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      nmi_prev_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end
    else
    begin
      nmi_prev_r <= i_int.nmi;
      if (i_int.nmi && !nmi_prev_r)
      begin
        nmi_pend_r <= 1'b1;
      end
      else if (nmi_take && !rst_take && !gex_take)
      begin
        nmi_pend_r <= 1'b0;
      end
    end
  end

  // completion causes seen at a branch/slot boundary wait for the next one
  always_ff @(posedge i_clk_sys)
  begin
    logic [CES_GEX_W:0] d;
    d = first_cause(i_bound.cause & CES_GEX_DONE);
    if (i_reset || rst_take)
    begin
      defer_r     <= 1'b0;
      defer_idx_r <= '0;
      defer_imm_r <= 8'h00;
    end
    else if (i_bound.valid && i_bound.gap && d[CES_GEX_W] && !defer_r)
    begin
      defer_r     <= 1'b1;
      defer_idx_r <= d[CES_GEX_W-1:0];
      defer_imm_r <= i_bound.trap_imm;
    end
    else if (bnd_ok && defer_r)
    begin
      defer_r <= 1'b0;
    end
  end

  // one entry per accept, boundaries ignored in the following cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_r <= CES_RUN;
    end
    else
    begin
      unique case (state_r)
        CES_RUN:
        begin
          if (rst_take || entry)
          begin
            state_r <= CES_ENTRY;
          end
        end
        CES_ENTRY:
        begin
          state_r <= CES_RUN;
        end
      endcase
    end
  end

  assign bus_acc = (i_avs.read | i_avs.write) & ~wait_r;
  assign bus_wr  = i_avs.write & ~wait_r;

  // status word, saved pc and saved status word
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      sw_r  <= CES_SW_RST;
      spc_r <= 32'h00000000;
      ssr_r <= 32'h00000000;
    end
    else if (rst_take || (gex_take && blocked))
    begin
      sw_r <= CES_SW_RST;
    end
    else if (entry && !i_rte)
    begin
      spc_r              <= entry_pc;
      ssr_r              <= sw_r;
      sw_r[CES_SW_BLOCK] <= 1'b1;
      sw_r[CES_SW_PRIV]  <= 1'b1;
      sw_r[CES_SW_BANK]  <= 1'b1;
    end
    else if (entry && i_rte)
    begin
      sw_r <= ssr_r;
    end
    else if (i_sw_load.valid)
    begin
      sw_r <= i_sw_load.data;
    end
    else if (bus_wr && i_avs.address == CES_ADDR_SAVED_PC)
    begin
      spc_r <= merge_be(spc_r, i_avs.writedata, i_avs.byteenable);
    end
    else if (bus_wr && i_avs.address == CES_ADDR_SAVED_SW)
    begin
      ssr_r <= merge_be(ssr_r, i_avs.writedata, i_avs.byteenable);
    end
  end

  // event code registers; hardware writes win over software writes
  always_ff @(posedge i_clk_sys)
  begin
    logic [31:0] m;
    m = 32'h00000000;
    if (i_reset)
    begin
      exc_code_r <= CES_CODE_POR;
      int_code_r <= 12'h000;
      int_alt_r  <= 12'h000;
      tra_r      <= 8'h00;
    end
    else if (por_now)
    begin
      exc_code_r <= CES_CODE_POR;
    end
    else if (man_now)
    begin
      exc_code_r <= CES_CODE_MAN;
    end
    else if (i_debug_port_reset)
    begin
      exc_code_r <= CES_CODE_DBGRST;
    end
    else if (gex_take)
    begin
      exc_code_r <= CES_GEX_CODE[gex_idx];
      if (gex_idx == CES_GEX_W'(CES_GEX_TRAP))
      begin
        tra_r <= gex_imm;
      end
    end
    else if (nmi_take)
    begin
      int_code_r <= CES_CODE_NMI;
      int_alt_r  <= CES_CODE_NMI;
    end
    else if (irq_take)
    begin
      if (i_int.irq)
      begin
        int_code_r <= i_int.irq_code;
        int_alt_r  <= i_int.irq_code;
      end
      else
      begin
        int_code_r <= CES_CODE_DBGINT;
        int_alt_r  <= CES_CODE_DBGINT;
      end
    end
    else if (bus_wr)
    begin
      unique case (i_avs.address)
        CES_ADDR_EXC_CODE:
        begin
          m = merge_be({20'h00000, exc_code_r}, i_avs.writedata,
                       i_avs.byteenable);
          exc_code_r <= m[11:0];
        end
        CES_ADDR_INT_CODE:
        begin
          m = merge_be({20'h00000, int_code_r}, i_avs.writedata,
                       i_avs.byteenable);
          int_code_r <= m[11:0];
        end
        CES_ADDR_TRAP_IMM:
        begin
          m = merge_be({24'h000000, tra_r}, i_avs.writedata,
                       i_avs.byteenable);
          tra_r <= m[7:0];
        end
        default:
        begin
          m = 32'h00000000;
        end
      endcase
    end
  end

  // vector base register, software owned
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      vbr_r <= 32'h00000000;
    end
    else if (bus_wr && i_avs.address == CES_ADDR_VBR)
    begin
      vbr_r <= merge_be(vbr_r, i_avs.writedata, i_avs.byteenable);
    end
  end

  // redirect to the handler, valid one cycle per accepted event, so every cycle while a reset is held
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      redir_r <= '0;
    end
    else if (rst_take)
    begin
      redir_r <= '{valid: 1'b1, core_reset: 1'b1,
                   target: CES_RESET_VEC};
    end
    else if (gex_take && blocked)
    begin
      redir_r <= '{valid: 1'b1, core_reset: 1'b1,
                   target: CES_RESET_VEC};
    end
    else if (gex_take && CES_GEX_MISS[gex_idx])
    begin
      redir_r <= '{valid: 1'b1, core_reset: 1'b0,
                   target: vbr_r + CES_OFS_MISS};
    end
    else if (gex_take)
    begin
      redir_r <= '{valid: 1'b1, core_reset: 1'b0,
                   target: vbr_r + CES_OFS_GEN};
    end
    else if (nmi_take || irq_take)
    begin
      redir_r <= '{valid: 1'b1, core_reset: 1'b0,
                   target: vbr_r + CES_OFS_INT};
    end
    else if (entry)
    begin
      redir_r <= '{valid: 1'b1, core_reset: 1'b0,
                   target: spc_r};
    end
    else
    begin
      redir_r <= '0;
    end
  end

  // avalon slave: waitrequest drops for one cycle after a request
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      wait_r <= 1'b1;
    end
    else if ((i_avs.read || i_avs.write) && wait_r)
    begin
      wait_r <= 1'b0;
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rdata_r <= 32'h00000000;
    end
    else if (i_avs.read && wait_r)
    begin
      unique case (i_avs.address)
        CES_ADDR_TRAP_IMM: rdata_r <= {24'h000000, tra_r};
        CES_ADDR_EXC_CODE: rdata_r <= {20'h00000, exc_code_r};
        CES_ADDR_INT_CODE: rdata_r <= {20'h00000, int_code_r};
        CES_ADDR_INT_ALT:  rdata_r <= {20'h00000, int_alt_r};
        CES_ADDR_VBR:      rdata_r <= vbr_r;
        CES_ADDR_STATUS:   rdata_r <= sw_r;
        CES_ADDR_SAVED_PC: rdata_r <= spc_r;
        CES_ADDR_SAVED_SW: rdata_r <= ssr_r;
        default:           rdata_r <= 32'h00000000;
      endcase
    end
    else if (!bus_acc)
    begin
      rdata_r <= 32'h00000000;
    end
  end

  assign o_avs_readdata      = rdata_r;
  assign o_avs_waitrequest   = wait_r;
  assign o_status_word       = sw_r;
  assign o_saved_pc          = spc_r;
  assign o_saved_status_word = ssr_r;
  assign o_redirect          = redir_r;

endmodule : ces_top

// ===== verilog/ces_pkg.sv
// package: constants and carrier types of the cpu exception sequencer
package ces_pkg;

  // register byte addresses on the avalon slave
  localparam logic [31:0] CES_ADDR_TRAP_IMM  = 32'hFFFFFFD0;
  localparam logic [31:0] CES_ADDR_EXC_CODE  = 32'h0FFFFFD4;
  localparam logic [31:0] CES_ADDR_INT_CODE  = 32'h0FFFFFD8;
  localparam logic [31:0] CES_ADDR_INT_ALT   = 32'h04000000;
  localparam logic [31:0] CES_ADDR_VBR       = 32'hFFFFFFE0;
  localparam logic [31:0] CES_ADDR_STATUS    = 32'hFFFFFFE4;
  localparam logic [31:0] CES_ADDR_SAVED_PC  = 32'hFFFFFFE8;
  localparam logic [31:0] CES_ADDR_SAVED_SW  = 32'hFFFFFFEC;

  // status word bit positions
  localparam int CES_SW_BLOCK = 2;
  localparam int CES_SW_PRIV  = 1;
  localparam int CES_SW_BANK  = 0;

  // reset values and interrupt event codes
  localparam logic [31:0] CES_SW_RST      = 32'h00000007;
  localparam logic [11:0] CES_CODE_POR    = 12'h000;
  localparam logic [11:0] CES_CODE_MAN    = 12'h020;
  localparam logic [11:0] CES_CODE_DBGRST = 12'h000;
  localparam logic [11:0] CES_CODE_NMI    = 12'h1C0;
  localparam logic [11:0] CES_CODE_DBGINT = 12'h620;

  // vector addresses
  localparam logic [31:0] CES_RESET_VEC = 32'hA0000000;
  localparam logic [31:0] CES_OFS_MISS  = 32'h00000400;
  localparam logic [31:0] CES_OFS_GEN   = 32'h00000100;
  localparam logic [31:0] CES_OFS_INT   = 32'h00000600;

  // general exception causes, index = order within one instruction
  localparam int CES_NUM_GEX = 18;
  localparam int CES_GEX_W   = 5;
  localparam logic [11:0] CES_GEX_CODE [CES_NUM_GEX] = '{
    12'h0E0, 12'h040, 12'h040, 12'h0A0, 12'h180, 12'h1A0,
    12'h0E0, 12'h100, 12'h040, 12'h060, 12'h040, 12'h060,
    12'h0A0, 12'h0C0, 12'h080, 12'h160, 12'h1E0, 12'h600};
  // causes that vector to the miss offset
  localparam logic [CES_NUM_GEX-1:0] CES_GEX_MISS = 18'h00302;
  // completion type causes (trap, user break, dma address error)
  localparam logic [CES_NUM_GEX-1:0] CES_GEX_DONE = 18'h38000;
  localparam int CES_GEX_TRAP = 15;

  typedef struct packed {
    logic [31:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ces_avs_req_t;

  typedef struct packed {
    logic                   valid;
    logic                   gap;
    logic [31:0]            pc;
    logic [31:0]            branch_pc;
    logic [CES_NUM_GEX-1:0] cause;
    logic [7:0]             trap_imm;
  } ces_bound_t;

  typedef struct packed {
    logic        nmi;
    logic        irq;
    logic [11:0] irq_code;
    logic        dbg_irq;
  } ces_int_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } ces_sw_load_t;

  typedef struct packed {
    logic        valid;
    logic        core_reset;
    logic [31:0] target;
  } ces_redir_t;

  typedef enum logic [0:0] {CES_RUN, CES_ENTRY} ces_state_t;

endpackage : ces_pkg

// ===== sim/ces_assertions.sv
// checker: port-level timing rules of the exception sequencer
`timescale 1ns/100ps
module ces_checker (
  input  wire logic           i_clk_sys,
  input  wire logic           i_reset,
  input  wire logic           i_power_on_reset_n,
  input  wire logic           i_manual_reset_n,
  input  wire logic           i_debug_port_reset,
  input  ces_pkg::ces_bound_t i_bound,
  input  wire logic           i_rte,
  input  ces_pkg::ces_avs_req_t i_avs,
  input  wire logic           o_avs_waitrequest,
  input  wire logic [31:0]    o_status_word,
  input  wire logic [31:0]    o_saved_pc,
  input  wire logic [31:0]    o_saved_status_word,
  input  ces_pkg::ces_redir_t o_redirect
);
  import ces_pkg::*;
  logic [2:0] quiet_r;
  logic       quiet;
  logic       gen_ok;
  // reset pins pass two sync flops, so wait them out
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !i_power_on_reset_n || !i_manual_reset_n
        || i_debug_port_reset)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  assign quiet  = (quiet_r == 3'h7) && !i_debug_port_reset;
  assign gen_ok = i_bound.valid && (i_bound.cause != '0) && !i_bound.gap
                  && quiet && !o_redirect.valid;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  save_state_a: assert property (
    gen_ok && !o_status_word[CES_SW_BLOCK] |=> o_redirect.valid
    && o_saved_pc == $past(i_bound.pc)
    && o_saved_status_word == $past(o_status_word))
    else $error("state not saved");
  sw_bits_a: assert property (
    gen_ok |=> o_status_word[CES_SW_BLOCK]
    && o_status_word[CES_SW_PRIV] && o_status_word[CES_SW_BANK])
    else $error("entry bits not set");
  blk_reset_a: assert property (
    gen_ok && o_status_word[CES_SW_BLOCK] |=> o_redirect.core_reset
    && o_redirect.target == CES_RESET_VEC)
    else $error("blocked exception not reset");
  reset_vec_a: assert property (
    o_redirect.valid && o_redirect.core_reset
    |-> o_redirect.target == CES_RESET_VEC)
    else $error("bad reset vector");
  bound_only_a: assert property (
    o_redirect.valid && !o_redirect.core_reset
    |-> $past(i_bound.valid) || $past(i_rte))
    else $error("entry off boundary");
  gap_hold_a: assert property (
    i_bound.valid && i_bound.gap && quiet && !i_rte
    && (i_bound.cause & ~CES_GEX_DONE) == '0 |=> !o_redirect.valid)
    else $error("entry inside branch gap");
  int_hold_a: assert property (
    o_status_word[CES_SW_BLOCK] && i_bound.valid && i_bound.cause == '0
    && !i_rte && quiet |=> !o_redirect.valid)
    else $error("interrupt taken while blocked");
  rte_back_a: assert property (
    i_rte && !i_bound.valid && quiet && !o_redirect.valid
    |=> o_redirect.valid && o_redirect.target == $past(o_saved_pc)
    && o_status_word == $past(o_saved_status_word))
    else $error("bad return");
  wait_one_a: assert property (
    (i_avs.read || i_avs.write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus wait");
  cover property (gen_ok ##1 o_redirect.valid);
  cover property (i_rte ##1 o_redirect.valid);
  cover property (o_redirect.valid && o_redirect.core_reset);
  cover property (o_redirect.valid && o_redirect.target[11:0] == 12'h600);
endmodule : ces_checker

bind ces_top ces_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_power_on_reset_n(i_power_on_reset_n),
  .i_manual_reset_n(i_manual_reset_n),
  .i_debug_port_reset(i_debug_port_reset), .i_bound(i_bound),
  .i_rte(i_rte), .i_avs(i_avs), .o_avs_waitrequest(o_avs_waitrequest),
  .o_status_word(o_status_word), .o_saved_pc(o_saved_pc),
  .o_saved_status_word(o_saved_status_word), .o_redirect(o_redirect));

// ===== sim/ces_core_model.sv
// model: instruction pipeline and interrupt controller beside the sequencer
`timescale 1ns/100ps
module ces_core_model (
  input  wire logic           i_clk_sys,
  input  wire logic           i_reset,
  input  wire logic           i_go,
  input  wire logic           i_gap,
  input  wire logic [3:0]     i_delay,
  input  wire logic [31:0]    i_pc,
  input  wire logic [17:0]    i_cause,
  input  wire logic           i_irq_req,
  input  wire logic           i_nmi_req,
  input  wire logic [11:0]    i_irq_code,
  input  wire logic           i_dbg_req,
  input  ces_pkg::ces_redir_t i_redirect,
  output ces_pkg::ces_bound_t o_bound,
  output ces_pkg::ces_int_t   o_int
);
  import ces_pkg::*;
  logic [3:0] cnt_r;
  logic       pend_r;
  ces_bound_t hold_r;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pend_r  <= 1'b0;
      cnt_r   <= 4'h0;
      o_bound <= '0;
    end
    else if (i_go)
    begin
      pend_r        <= 1'b1;
      cnt_r         <= i_delay;
      hold_r        <= '{1'b1, i_gap, i_pc, i_pc - 32'h2, i_cause, i_pc[9:2]};
      o_bound.valid <= 1'b0;
    end
    else if (pend_r && cnt_r == 4'h0)
    begin
      // boundary shows only once the instruction has finished
      o_bound <= hold_r;
      pend_r  <= 1'b0;
    end
    else
    begin
      // fields carry no meaning outside the boundary pulse
      o_bound <= ces_bound_t'({1'b0, ~o_bound[$bits(ces_bound_t)-2:0]});
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
  end
  // requests stay up until vectored to the interrupt offset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_int <= '0;
    else
    begin
      if (i_redirect.valid && !i_redirect.core_reset
          && i_redirect.target[11:0] == 12'h600)
      begin
        if (o_int.nmi)
          o_int.nmi <= 1'b0;
        else if (o_int.irq)
          o_int.irq <= 1'b0;
        else
          o_int.dbg_irq <= 1'b0;
      end
      if (i_nmi_req)
        o_int.nmi <= 1'b1;
      if (i_irq_req)
        o_int.irq <= 1'b1;
      if (i_dbg_req)
        o_int.dbg_irq <= 1'b1;
      o_int.irq_code <= i_irq_code;
    end
  end
endmodule : ces_core_model

// ===== sim/ces_top_tb.sv
// testbench: random and corner-case checks of the exception sequencer
`timescale 1ns/100ps
module cpu_exception_sequencer_tb;
  import ces_pkg::*;
  logic         clk, rst, por_n, man_n, dbg, return_from_exception_instr, go, gap, irq, nmi;
  logic         wreq, hit, cr, dbgi;
  logic [3:0]   dly;
  logic [11:0]  icode;
  logic [17:0]  cause;
  logic [31:0]  pc, rd, vector_base_register, lfsr, sw, rdata, saved_program_counter, ssw, tgt, ld;
  int           err_count, checks, k;
  ces_sw_load_t swl;
  ces_avs_req_t avs;
  ces_bound_t   bnd;
  ces_int_t     intr;
  ces_redir_t   redir;
  logic [11:0]  code_tab [18] = '{12'h0E0, 12'h040, 12'h040, 12'h0A0,
    12'h180, 12'h1A0, 12'h0E0, 12'h100, 12'h040, 12'h060, 12'h040,
    12'h060, 12'h0A0, 12'h0C0, 12'h080, 12'h160, 12'h1E0, 12'h600};

  ces_top DUT (.i_clk_sys(clk), .i_reset(rst), .i_power_on_reset_n(por_n),
    .i_manual_reset_n(man_n), .i_debug_port_reset(dbg), .i_bound(bnd),
    .i_int(intr), .i_rte(return_from_exception_instr), .i_sw_load(swl), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_status_word(sw),
    .o_saved_pc(saved_program_counter), .o_saved_status_word(ssw), .o_redirect(redir));
  ces_core_model PM (.i_clk_sys(clk), .i_reset(rst), .i_go(go),
    .i_gap(gap), .i_delay(dly), .i_pc(pc), .i_cause(cause),
    .i_irq_req(irq), .i_nmi_req(nmi), .i_irq_code(icode),
    .i_dbg_req(dbgi), .i_redirect(redir), .o_bound(bnd), .o_int(intr));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  function automatic int low(input logic [17:0] c);
    for (int i = 0; i < 18; i++)
      if (c[i])
        return i;
    return 0;
  endfunction : low
  function automatic logic [31:0] ofs(input int i);
    return (i == 1 || i == 8 || i == 9) ? 32'h400 : 32'h100;
  endfunction : ofs

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    avs <= '{a, ~w, w, d, 4'hF};
    do @(posedge clk);
    while (wreq !== 1'b0);
    rd = rdata;
    avs <= '{a, 1'b0, 1'b0, d, 4'hF};
  endtask : bus
  task automatic issue(input logic [17:0] c, input logic g);
    @(posedge clk);
    lfsr = step(lfsr);
    pc    <= {lfsr[31:12], 4'h0, lfsr[7:1], 1'b0};
    cause <= c;
    gap   <= g;
    dly   <= lfsr[11:8];
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : issue
  task automatic await();
    hit = 1'b0;
    repeat (24)
    begin
      @(posedge clk);
      if (!hit && redir.valid === 1'b1)
      begin
        hit = 1'b1;
        tgt = redir.target;
        cr  = redir.core_reset;
      end
    end
  endtask : await
  // status loads come from code in a fixed untranslated region
  task automatic load(input logic [31:0] d);
    @(posedge clk);
    swl <= '{1'b1, d};
    @(posedge clk);
    swl <= '{1'b0, d};
  endtask : load
  task automatic code(input logic [31:0] a, exp);
    bus(1'b0, a, '0);
    chk("event code", rd, exp);
  endtask : code
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial
  begin
    {rst, por_n, man_n, dbg, return_from_exception_instr, go, gap, irq, nmi} = 9'h1C0;
    {dly, cause, pc, icode, swl, avs, dbgi} = '0;
    lfsr = 32'h6CC3;
    err_count = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    await();
    chk("reset vector", tgt, CES_RESET_VEC);
    code(CES_ADDR_EXC_CODE, 32'h0);
    bus(1'b0, 32'h00000010, '0);
    chk("unmapped", rd, 32'h0);
    bus(1'b0, CES_ADDR_INT_ALT, '0);
    ld = rd;
    bus(1'b1, CES_ADDR_INT_ALT, ~ld);
    bus(1'b0, CES_ADDR_INT_ALT, '0);
    chk("read-only", rd, ld);
    lfsr = step(lfsr);
    vector_base_register = {lfsr[31:12], 12'h000};
    bus(1'b1, CES_ADDR_VBR, vector_base_register);
    for (k = 0; k < 26; k++)
    begin
      lfsr = step(lfsr);
      ld = {30'h0, lfsr[1:0]};
      load(ld);
      issue(k < 18 ? 18'h1 << k : lfsr[17:0] | 18'h20000, 1'b0);
      await();
      chk("target", tgt, vector_base_register + ofs(low(cause)));
      chk("saved pc", saved_program_counter, pc);
      chk("saved sw", ssw, ld);
      chk("sw bits", {29'h0, sw[2:0]}, 32'h7);
      code(CES_ADDR_EXC_CODE, {20'h0, code_tab[low(cause)]});
      if (low(cause) == 15)
        code(CES_ADDR_TRAP_IMM, {24'h0, pc[9:2]});
    end
    issue(18'h10, 1'b0);
    await();
    chk("blocked", {cr, tgt}, {1'b1, CES_RESET_VEC});
    bus(1'b1, CES_ADDR_VBR, vector_base_register);
    lfsr = step(lfsr);
    @(posedge clk);
    icode <= {4'h2, lfsr[2:0], 5'h00};
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    issue(18'h0, 1'b0);
    await();
    chk("held", {31'h0, hit}, 32'h0);
    load(32'h0);
    issue(18'h0, 1'b0);
    await();
    chk("int target", tgt, vector_base_register + 32'h600);
    chk("int saved pc", saved_program_counter, pc);
    code(CES_ADDR_INT_CODE, {20'h0, icode});
    code(CES_ADDR_INT_ALT, {20'h0, icode});
    @(posedge clk);
    {nmi, irq} <= 2'b11;
    @(posedge clk);
    {nmi, irq} <= 2'b00;
    load(32'h0);
    issue(18'h4, 1'b0);
    await();
    chk("general first", tgt, vector_base_register + 32'h100);
    load(32'h0);
    issue(18'h0, 1'b0);
    await();
    code(CES_ADDR_INT_CODE, 32'h1C0);
    load(32'h0);
    issue(18'h0, 1'b0);
    await();
    code(CES_ADDR_INT_CODE, {20'h0, icode});
    @(posedge clk);
    dbgi <= 1'b1;
    @(posedge clk);
    dbgi <= 1'b0;
    load(32'h0);
    issue(18'h0, 1'b0);
    await();
    chk("debug int", tgt, vector_base_register + 32'h600);
    code(CES_ADDR_INT_ALT, {20'h0, CES_CODE_DBGINT});
    @(posedge clk);
    dbg <= 1'b1;
    @(posedge clk);
    dbg <= 1'b0;
    await();
    chk("debug reset", tgt, CES_RESET_VEC);
    code(CES_ADDR_EXC_CODE, 32'h0);
    bus(1'b1, CES_ADDR_VBR, vector_base_register);
    load(32'h0);
    issue(18'h8000, 1'b1);
    await();
    chk("gap", {31'h0, hit}, 32'h0);
    issue(18'h2, 1'b0);
    await();
    chk("deferred", tgt, vector_base_register + 32'h100);
    code(CES_ADDR_EXC_CODE, 32'h160);
    load(32'h0);
    issue(18'h10, 1'b1);
    await();
    chk("slot pc", saved_program_counter, pc - 32'h2);
    @(posedge clk);
    return_from_exception_instr <= 1'b1;
    @(posedge clk);
    return_from_exception_instr <= 1'b0;
    await();
    chk("return pc", tgt, pc - 32'h2);
    chk("return sw", sw, 32'h0);
    @(posedge clk);
    man_n <= 1'b0;
    repeat (4) @(posedge clk);
    man_n <= 1'b1;
    repeat (8) @(posedge clk);
    code(CES_ADDR_EXC_CODE, 32'h20);
    por_n <= 1'b0;
    repeat (4) @(posedge clk);
    por_n <= 1'b1;
    await();
    chk("pin reset", {cr, tgt}, {1'b1, CES_RESET_VEC});
    code(CES_ADDR_EXC_CODE, 32'h0);
    summarize();
  end
endmodule : cpu_exception_sequencer_tb
